// File: rtl/wdt_pkg.sv
// Package with constants, register map and carrier types for the watchdog block
package wdt_pkg;

	// Timing: nominal base period and the reference clock period
	localparam int CLK_PERIOD_NS = 20;
	localparam int WDT_BASE_NS = 18000000;
	localparam int WDT_BASE_CYCLES = WDT_BASE_NS / CLK_PERIOD_NS;
	localparam int BASE_CNT_W = 20;
	localparam int PRESC_W = 8;
	localparam int RATE_W = 3;

	// Register bus
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] REG_STATUS = 3'h0;
	localparam logic [ADDR_W-1:0] REG_OPTION = 3'h1;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 3'h2;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 3'h3;

	// Field positions and reset values
	localparam int STAT_TIMEOUT_BIT = 4;
	localparam int STAT_PWRDN_BIT = 3;
	localparam logic [DATA_W-1:0] STATUS_RST = 8'h18;
	localparam logic [DATA_W-1:0] OPTION_RST = 8'hFF;
	localparam int IRQ_W = 2;
	localparam int IRQ_RESET_BIT = 0;
	localparam int IRQ_WAKE_BIT = 1;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

	typedef struct packed {
		logic pullup_n;
		logic int_edge;
		logic t0_clk_sel;
		logic t0_edge;
		logic prescaler_assign_select;
		logic [RATE_W-1:0] prescale_rate;
	} wdt_option_s;

	typedef struct packed {
		logic clear_watchdog_instruction;
		logic sleep_instruction;
		logic ext_wake;
	} wdt_core_evt_s;

	typedef enum logic [1:0] {
		WDT_AWAKE = 2'h0,
		WDT_ASLEEP = 2'h1,
		WDT_WAKING = 2'h3
	} wdt_sleep_e;

endpackage

// File: rtl/wdt_divider.sv
// Clearable enable-driven divider used for the base period and the prescaler
`timescale 1ns/1ps
module wdt_divider #(
	parameter int W = 8
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clr,
	input wire logic en,
	input wire logic [W-1:0] limit,
	output logic [W-1:0] count,
	output logic tick
);

	logic [W-1:0] count_ff;

	assign count = count_ff;
	// Compare with >= so a limit lowered on the fly never lets the count run past it
	assign tick = en && !clr && (count_ff >= (limit - W'(1)));

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			count_ff <= '0;
		end else if (clr) begin
			count_ff <= '0;
		end else if (en) begin
			if (tick) begin
				count_ff <= '0;
			end else begin
				count_ff <= count_ff + W'(1);
			end
		end
	end

	clear_zeroes_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		clr |=> (count_ff == '0))
		else $error("divider count not zero after clear");

	tick_wraps_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		tick |=> (count_ff == '0) && !tick)
		else $error("divider did not wrap after tick");

endmodule

// File: rtl/wdt_top.sv
// Watchdog timer: base divider, assignable prescaler, sleep tracking and registers
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps

// Overview of operation
// - Enable fuse set: watchdog counts freely
// - Timeout while running resets the device
// - Timeout in sleep wakes, execution continues
// - Fuse cleared: never reset, never wake
// - Software changes prescaler assignment any time
// - Unscaled timeout is nominal 18 ms
// - Assigned prescaler stretches timeout, up to 128
// - Clear or sleep instruction restarts counts
// - Timeout clears the active-low timeout flag
module wdt_top #(
	parameter int BASE_CYCLES = wdt_pkg::WDT_BASE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic watchdog_enable_fuse,
	input wire wdt_pkg::wdt_core_evt_s core_evt,
	input wire logic [wdt_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [wdt_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [wdt_pkg::DATA_W-1:0] reg_rdata,
	output logic wdt_reset_req,
	output logic cpu_wake,
	output logic cpu_sleeping,
	output logic irq
);

	logic fuse_s1_ff;
	logic fuse_s2_ff;
	logic fuse_s3_ff;
	logic fuse_on_ff;
	wdt_pkg::wdt_sleep_e sleep_ff;
	wdt_pkg::wdt_sleep_e nxt_sleep;
	wdt_pkg::wdt_option_s option_ff;
	logic timeout_status_flag_n_ff;
	logic powerdown_status_flag_n_ff;
	logic [wdt_pkg::DATA_W-1:0] status_misc_ff;
	logic [wdt_pkg::DATA_W-1:0] status_view;
	logic [wdt_pkg::IRQ_W-1:0] irq_stat_ff;
	logic [wdt_pkg::IRQ_W-1:0] irq_mask_ff;
	logic [wdt_pkg::IRQ_W-1:0] irq_events;
	logic [wdt_pkg::DATA_W-1:0] rdata_ff;
	logic reset_req_ff;
	logic wake_ff;
	logic restart;
	logic sleep_exit;
	logic clr_base;
	logic clr_presc;
	logic base_tick;
	logic timeout;
	logic [wdt_pkg::BASE_CNT_W-1:0] base_count;
	logic [wdt_pkg::PRESC_W-1:0] presc_count;
	logic [wdt_pkg::PRESC_W-1:0] presc_limit;
	logic asleep;
	logic wr_status;
	logic wr_option;
	logic wr_irq_stat;
	logic wr_irq_mask;

	// Fuse pin: accepted once the second and third stages agree
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			fuse_s1_ff <= 1'b0;
			fuse_s2_ff <= 1'b0;
			fuse_s3_ff <= 1'b0;
		end else begin
			fuse_s1_ff <= watchdog_enable_fuse;
			fuse_s2_ff <= fuse_s1_ff;
			fuse_s3_ff <= fuse_s2_ff;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			fuse_on_ff <= 1'b0;
		end else if (fuse_s2_ff == fuse_s3_ff) begin
			fuse_on_ff <= fuse_s3_ff;
		end
	end

	// Sleep tracking; the waking state lasts one cycle and clears the counts
	assign asleep = (sleep_ff == wdt_pkg::WDT_ASLEEP);
	assign sleep_exit = (sleep_ff == wdt_pkg::WDT_WAKING);

	always_comb begin
		nxt_sleep = sleep_ff;
		case (sleep_ff)
			wdt_pkg::WDT_AWAKE: begin
				if (core_evt.sleep_instruction) begin
					nxt_sleep = wdt_pkg::WDT_ASLEEP;
				end
			end
			wdt_pkg::WDT_ASLEEP: begin
				if (timeout || core_evt.ext_wake) begin
					nxt_sleep = wdt_pkg::WDT_WAKING;
				end
			end
			wdt_pkg::WDT_WAKING: begin
				nxt_sleep = wdt_pkg::WDT_AWAKE;
			end
			default: begin
				nxt_sleep = wdt_pkg::WDT_AWAKE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sleep_ff <= wdt_pkg::WDT_AWAKE;
		end else begin
			sleep_ff <= nxt_sleep;
		end
	end

	// Count clearing
	assign restart = core_evt.clear_watchdog_instruction || core_evt.sleep_instruction;
	assign clr_base = !fuse_on_ff || restart || sleep_exit;
	// The prescaler is shared; a restart only clears it while it serves the watchdog
	assign clr_presc = !fuse_on_ff || sleep_exit || (restart && option_ff.prescaler_assign_select);

	// Unassigned prescaler passes every base period straight through
	assign presc_limit = option_ff.prescaler_assign_select ?
		(wdt_pkg::PRESC_W'(1) << option_ff.prescale_rate) : wdt_pkg::PRESC_W'(1);

	wdt_divider #(
		.W(wdt_pkg::BASE_CNT_W)
	) u_base (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.clr(clr_base),
		.en(1'b1),
		.limit(wdt_pkg::BASE_CNT_W'(BASE_CYCLES)),
		.count(base_count),
		.tick(base_tick)
	);

	wdt_divider #(
		.W(wdt_pkg::PRESC_W)
	) u_presc (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.clr(clr_presc),
		.en(base_tick),
		.limit(presc_limit),
		.count(presc_count),
		.tick(timeout)
	);

	// Timeout outcome: a reset request when running, a wake-up when asleep
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			reset_req_ff <= 1'b0;
			wake_ff <= 1'b0;
		end else begin
			reset_req_ff <= timeout && fuse_on_ff && !asleep;
			wake_ff <= timeout && fuse_on_ff && asleep;
		end
	end

	assign wdt_reset_req = reset_req_ff;
	assign cpu_wake = wake_ff;
	assign cpu_sleeping = asleep;

	// Register writes
	assign wr_status = reg_wr && (reg_addr == wdt_pkg::REG_STATUS);
	assign wr_option = reg_wr && (reg_addr == wdt_pkg::REG_OPTION);
	assign wr_irq_stat = reg_wr && (reg_addr == wdt_pkg::REG_IRQ_STAT);
	assign wr_irq_mask = reg_wr && (reg_addr == wdt_pkg::REG_IRQ_MASK);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			option_ff <= wdt_pkg::OPTION_RST;
		end else if (wr_option) begin
			option_ff <= reg_wdata;
		end
	end

	// Flag bits are read-only to software and survive the device reset they request
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			timeout_status_flag_n_ff <= wdt_pkg::STATUS_RST[wdt_pkg::STAT_TIMEOUT_BIT];
		end else if (timeout) begin
			timeout_status_flag_n_ff <= 1'b0;
		end else if (restart) begin
			timeout_status_flag_n_ff <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			powerdown_status_flag_n_ff <= wdt_pkg::STATUS_RST[wdt_pkg::STAT_PWRDN_BIT];
		end else if (core_evt.sleep_instruction) begin
			powerdown_status_flag_n_ff <= 1'b0;
		end else if (core_evt.clear_watchdog_instruction) begin
			powerdown_status_flag_n_ff <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			status_misc_ff <= wdt_pkg::STATUS_RST;
		end else if (wr_status) begin
			status_misc_ff <= reg_wdata;
		end
	end

	always_comb begin
		status_view = status_misc_ff;
		status_view[wdt_pkg::STAT_TIMEOUT_BIT] = timeout_status_flag_n_ff;
		status_view[wdt_pkg::STAT_PWRDN_BIT] = powerdown_status_flag_n_ff;
	end

	// Interrupt status: events set, write one clears, a set in the same cycle wins
	always_comb begin
		irq_events = '0;
		irq_events[wdt_pkg::IRQ_RESET_BIT] = reset_req_ff;
		irq_events[wdt_pkg::IRQ_WAKE_BIT] = wake_ff;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			irq_stat_ff <= '0;
		end else if (wr_irq_stat) begin
			irq_stat_ff <= (irq_stat_ff & ~reg_wdata[wdt_pkg::IRQ_W-1:0]) | irq_events;
		end else begin
			irq_stat_ff <= irq_stat_ff | irq_events;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			irq_mask_ff <= wdt_pkg::IRQ_MASK_RST;
		end else if (wr_irq_mask) begin
			irq_mask_ff <= reg_wdata[wdt_pkg::IRQ_W-1:0];
		end
	end

	assign irq = |(irq_stat_ff & irq_mask_ff);

	// Read data stands in the cycle after the strobe only; unmapped reads return zero
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				wdt_pkg::REG_STATUS: begin
					rdata_ff <= status_view;
				end
				wdt_pkg::REG_OPTION: begin
					rdata_ff <= option_ff;
				end
				wdt_pkg::REG_IRQ_STAT: begin
					rdata_ff <= {{(wdt_pkg::DATA_W-wdt_pkg::IRQ_W){1'b0}}, irq_stat_ff};
				end
				wdt_pkg::REG_IRQ_MASK: begin
					rdata_ff <= {{(wdt_pkg::DATA_W-wdt_pkg::IRQ_W){1'b0}}, irq_mask_ff};
				end
				default: begin
					rdata_ff <= '0;
				end
			endcase
		end else begin
			rdata_ff <= '0;
		end
	end

	assign reg_rdata = rdata_ff;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	fuse_off_quiet_a: assert property (!fuse_on_ff |-> !timeout ##1 (!wdt_reset_req && !cpu_wake))
		else $error("watchdog acted with fuse cleared");

	fuse_hold_clear_a: assert property (!fuse_on_ff |=> (base_count == '0) && (presc_count == '0))
		else $error("counts not held clear with fuse cleared");

	fuse_runs_a: assert property ((fuse_on_ff && !clr_base) |=> (base_count != '0) || $past(base_tick))
		else $error("base counter not running with fuse set");

	reset_when_run_a: assert property ((timeout && !asleep) |=> wdt_reset_req && !cpu_wake)
		else $error("timeout while running gave no reset");

	wake_in_sleep_a: assert property ((timeout && asleep) |=> cpu_wake && !wdt_reset_req ##1 !asleep)
		else $error("timeout in sleep gave no clean wake-up");

	option_write_a: assert property (wr_option |=> (option_ff == $past(reg_wdata)))
		else $error("option write not taken");

	base_period_a: assert property (base_tick |-> (base_count == wdt_pkg::BASE_CNT_W'(BASE_CYCLES - 1)))
		else $error("base period not at nominal count");

	presc_ratio_a: assert property (timeout |-> base_tick && (presc_count >= presc_limit - wdt_pkg::PRESC_W'(1)))
		else $error("timeout not at selected ratio");

	restart_clear_a: assert property (restart |=> (base_count == '0) && !timeout)
		else $error("restart did not clear the count");

	to_flag_clear_a: assert property (timeout |=> !timeout_status_flag_n_ff ##1 (!timeout_status_flag_n_ff || $past(restart)))
		else $error("timeout flag not cleared on timeout");

	sleep_exit_clear_a: assert property (sleep_exit |=> (base_count == '0) && (presc_count == '0))
		else $error("counts not cleared at sleep exit");

	irq_sticky_a: assert property ((wdt_reset_req && !wr_irq_stat) |=> irq_stat_ff[wdt_pkg::IRQ_RESET_BIT])
		else $error("reset event not latched in interrupt status");

endmodule

// File: tb/wdt_top_bench.sv
// Self-checking bench for the watchdog block
`timescale 1ns/1ps
module wdt_top_bench;
	localparam int BC = 8;
	logic ref_clk = 0;
	logic resetn = 0;
	logic fuse = 1;
	wdt_pkg::wdt_core_evt_s evt = '0;
	logic [2:0] addr = '0;
	logic [7:0] wdata = '0;
	logic wr = 0;
	logic rd = 0;
	logic [7:0] rdata;
	logic rst_req;
	logic wake;
	logic sleeping;
	logic irq;
	int failures = 0;
	int tests_run = 0;
	int n_req = 0;
	int n_wk = 0;
	int n;
	int a;
	int b;
	logic [31:0] rnd = 32'hAFCE;
	logic [7:0] s;
	logic [7:0] d;
	logic [7:0] q;

	wdt_top #(.BASE_CYCLES(BC)) dut (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.watchdog_enable_fuse(fuse),
		.core_evt(evt),
		.reg_addr(addr),
		.reg_wdata(wdata),
		.reg_wr(wr),
		.reg_rd(rd),
		.reg_rdata(rdata),
		.wdt_reset_req(rst_req),
		.cpu_wake(wake),
		.cpu_sleeping(sleeping),
		.irq(irq)
	);

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	always @(negedge ref_clk) begin
		if (rst_req === 1'b1)
			n_req++;
		if (wake === 1'b1)
			n_wk++;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// Cycles from restart to the output pulse, sampled at the falling edge
	function automatic int exp_cyc(input logic assigned, input logic [2:0] rate);
		return (assigned ? (BC << rate) : BC) + 1;
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic wr_reg(input logic [2:0] ad, input logic [7:0] v);
		@(posedge ref_clk);
		wr <= 1;
		addr <= ad;
		wdata <= v;
		@(posedge ref_clk);
		wr <= 0;
	endtask

	task automatic rd_reg(input logic [2:0] ad, output logic [7:0] v);
		@(posedge ref_clk);
		rd <= 1;
		addr <= ad;
		@(posedge ref_clk);
		rd <= 0;
		@(negedge ref_clk);
		v = rdata;
	endtask

	task automatic pulse(input logic slp);
		@(posedge ref_clk);
		evt.clear_watchdog_instruction <= !slp;
		evt.sleep_instruction <= slp;
		@(posedge ref_clk);
		evt <= '0;
	endtask

	// Counts from the strobe cycle; the cycle after it is skipped, where an older pulse may still show
	task automatic wait_out(output int k);
		k = 2;
		@(negedge ref_clk);
		@(negedge ref_clk);
		while (rst_req !== 1'b1 && wake !== 1'b1 && k < 3000) begin
			@(negedge ref_clk);
			k++;
		end
	endtask

	task automatic finish_test;
		$display("Ran %0d compares, %0d mismatches", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// The whole run takes about 4000 cycles; this allows five times that
	initial begin
		#400000;
		failures++;
		finish_test();
	end

	initial begin
		repeat (10) @(posedge ref_clk);
		resetn <= 1;
		rd_reg(wdt_pkg::REG_STATUS, d);
		chk("status rst", 8'h18, d);
		rd_reg(wdt_pkg::REG_OPTION, d);
		chk("option rst", 8'hFF, d);
		rd_reg(wdt_pkg::REG_IRQ_MASK, d);
		chk("mask rst", 8'h00, d);
		rd_reg(3'h5, d);
		chk("unmapped", 8'h00, d);
		rnd = lfsr(rnd);
		s = rnd[7:0] & 8'hE7;
		wr_reg(wdt_pkg::REG_STATUS, rnd[7:0]);
		rd_reg(wdt_pkg::REG_STATUS, d);
		chk("status rw", s | 8'h18, d);
		for (int i = 0; i <= 8; i++) begin
			rnd = lfsr(rnd);
			d = {rnd[7:4], i < 8, i < 8 ? 3'(i) : rnd[2:0]};
			wr_reg(wdt_pkg::REG_OPTION, d);
			rd_reg(wdt_pkg::REG_OPTION, q);
			chk("option rw", d, q);
			pulse(0);
			wait_out(n);
			chk("period", exp_cyc(d[3], d[2:0]), n);
			chk("reset req", 2'b10, {rst_req, wake});
		end
		rd_reg(wdt_pkg::REG_STATUS, d);
		chk("flag after timeout", s | 8'h08, d);
		wr_reg(wdt_pkg::REG_OPTION, 8'h09);
		a = n_req;
		repeat (25) begin
			rnd = lfsr(rnd);
			pulse(0);
			repeat (rnd[2:0] + 2) @(posedge ref_clk);
		end
		chk("no timeout", a, n_req);
		wr_reg(wdt_pkg::REG_OPTION, 8'h0F);
		wr_reg(wdt_pkg::REG_IRQ_STAT, 8'h03);
		wr_reg(wdt_pkg::REG_IRQ_MASK, 8'h03);
		rd_reg(wdt_pkg::REG_IRQ_STAT, d);
		chk("irq clr", 8'h00, d);
		chk("irq low", 1'b0, irq);
		pulse(0);
		wait_out(n);
		chk("long period", exp_cyc(1, 7), n);
		repeat (2) @(negedge ref_clk);
		chk("irq set", 1'b1, irq);
		wr_reg(wdt_pkg::REG_IRQ_MASK, 8'h02);
		repeat (2) @(negedge ref_clk);
		chk("irq masked", 1'b0, irq);
		wr_reg(wdt_pkg::REG_IRQ_STAT, 8'h01);
		wr_reg(wdt_pkg::REG_OPTION, 8'h0B);
		pulse(1);
		rd_reg(wdt_pkg::REG_STATUS, d);
		chk("status asleep", s | 8'h10, d);
		chk("asleep", 1'b1, sleeping);
		a = n_req;
		wait_out(n);
		chk("wake", 1'b1, wake);
		chk("no reset in sleep", a, n_req);
		repeat (2) @(negedge ref_clk);
		chk("awake", 1'b0, sleeping);
		chk("irq wake", 1'b1, irq);
		rd_reg(wdt_pkg::REG_IRQ_STAT, d);
		chk("wake event", 8'h02, d);
		wr_reg(wdt_pkg::REG_OPTION, 8'h00);
		pulse(1);
		wait_out(n);
		chk("sleep period", exp_cyc(0, 0), n);
		chk("wake only", 2'b01, {rst_req, wake});
		@(posedge ref_clk);
		fuse <= 0;
		repeat (6) @(posedge ref_clk);
		a = n_req;
		b = n_wk;
		pulse(0);
		repeat (200) @(posedge ref_clk);
		pulse(1);
		repeat (200) @(posedge ref_clk);
		chk("fuse off req", a, n_req);
		chk("fuse off wake", b, n_wk);
		chk("still asleep", 1'b1, sleeping);
		// Another wake source leaves sleep without a watchdog wake pulse
		@(posedge ref_clk);
		evt.ext_wake <= 1;
		@(posedge ref_clk);
		evt <= '0;
		@(negedge ref_clk);
		chk("other wake", 1'b0, sleeping);
		chk("no wake pulse", b, n_wk);
		finish_test();
	end
endmodule
